// ==== hdl/jdrc_map.vh ====
// Constants shared by the scan-chain block: instruction codes, chain lengths and reset values.
`ifndef JDRC_MAP_VH
`define JDRC_MAP_VH

// Instruction register width and codes.
`define JDRC_IR_W 4
`define JDRC_IR_EXTEST 4'h0
`define JDRC_IR_INTEST 4'h1
`define JDRC_IR_SAMPLE 4'h2
`define JDRC_IR_CANCEL 4'h8
`define JDRC_IR_DP_CHAIN 4'hA
`define JDRC_IR_AP_CHAIN 4'hB
`define JDRC_IR_IDCODE 4'hE
`define JDRC_IR_BYPASS 4'hF
// Fixed pattern loaded into the instruction shifter in Capture-IR.
`define JDRC_IR_CAPTURE 4'h1

// Chain lengths.
`define JDRC_ID_W 32
`define JDRC_DBG_W 35
`define JDRC_NUM_PADS 8
`define JDRC_CELLS_PER_PAD 3
`define JDRC_BSR_W 24

// Cell positions inside one pad group.
`define JDRC_CELL_IN 0
`define JDRC_CELL_OUT 1
`define JDRC_CELL_OE 2

// Identification constant; the value is arbitrary and bit 0 is always forced to one.
`define JDRC_IDCODE 32'h0ABC_D001

// Reset values.
`define JDRC_BYPASS_CAPTURE 1'b0

`endif

// ==== hdl/jdrc_bsr.v ====
// Boundary-scan register: capture, shift and update cells for every pad.
`timescale 1ns/100ps
`include "jdrc_map.vh"

module jdrc_bsr (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire capture_i,
    input wire shift_i,
    input wire update_i,
    input wire tdi_i,
    input wire extest_i,
    input wire intest_i,
    input wire [`JDRC_NUM_PADS-1:0] pad_in_i,
    input wire [`JDRC_NUM_PADS-1:0] core_out_i,
    input wire [`JDRC_NUM_PADS-1:0] core_oe_i,
    output wire so_o,
    output reg [`JDRC_NUM_PADS-1:0] pad_out_o,
    output reg [`JDRC_NUM_PADS-1:0] pad_oe_o,
    output reg [`JDRC_NUM_PADS-1:0] core_in_o
);

    reg [`JDRC_NUM_PADS-1:0] pin_meta_q;
    reg [`JDRC_NUM_PADS-1:0] pin_sync_q;
    reg [`JDRC_BSR_W-1:0] shift_q;
    reg [`JDRC_BSR_W-1:0] hold_q;
    wire [`JDRC_BSR_W-1:0] sample_w;

    // Pad 0 sits nearest the port pins, so its cells leave first on TDO.
    assign so_o = shift_q[0];

    ////////////////////////////////////////////////////////////////////////////////
    // Pad inputs come from outside the clock domain and pass two flip-flops.
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pin_meta_q <= {`JDRC_NUM_PADS{1'b0}};
            pin_sync_q <= {`JDRC_NUM_PADS{1'b0}};
        end else begin
            pin_meta_q <= pad_in_i;
            pin_sync_q <= pin_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Each pad contributes input, output and enable cells in that order.
    genvar g;
    generate
        for (g = 0; g < `JDRC_NUM_PADS; g = g + 1) begin : g_pad
            assign sample_w[g*3+`JDRC_CELL_IN] = pin_sync_q[g];
            assign sample_w[g*3+`JDRC_CELL_OUT] = core_out_i[g];
            assign sample_w[g*3+`JDRC_CELL_OE] = core_oe_i[g];

            // Outputs are registered so the pads never see a mux glitch.
            always @(posedge clk_sys_i) begin
                if (!rst_n_i) begin
                    pad_out_o[g] <= 1'b0;
                    pad_oe_o[g] <= 1'b0;
                    core_in_o[g] <= 1'b0;
                end else begin
                    pad_out_o[g] <= extest_i ? hold_q[g*3+`JDRC_CELL_OUT] : core_out_i[g];
                    pad_oe_o[g] <= extest_i ? hold_q[g*3+`JDRC_CELL_OE] : core_oe_i[g];
                    core_in_o[g] <= intest_i ? hold_q[g*3+`JDRC_CELL_IN] : pin_sync_q[g];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Capture samples all pads, shift moves toward TDO, update loads the holding latches.
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            shift_q <= {`JDRC_BSR_W{1'b0}};
            hold_q <= {`JDRC_BSR_W{1'b0}};
        end else begin
            if (capture_i) begin
                shift_q <= sample_w;
            end else if (shift_i) begin
                shift_q <= {tdi_i, shift_q[`JDRC_BSR_W-1:1]};
            end
            if (update_i) begin
                hold_q <= shift_q;
            end
        end
    end

endmodule

// ==== hdl/jdrc_chains.v ====
// Test access port data chains: identification, bypass, boundary and debug-access chains.
`timescale 1ns/100ps
`include "jdrc_map.vh"


module jdrc_chains (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire tck_i,
    input wire tms_i,
    input wire tdi_i,
    input wire trst_n_i,
    output reg tdo_o,
    output reg tdo_oe_o,
    input wire [`JDRC_NUM_PADS-1:0] pad_in_i,
    input wire [`JDRC_NUM_PADS-1:0] core_out_i,
    input wire [`JDRC_NUM_PADS-1:0] core_oe_i,
    output wire [`JDRC_NUM_PADS-1:0] pad_out_o,
    output wire [`JDRC_NUM_PADS-1:0] pad_oe_o,
    output wire [`JDRC_NUM_PADS-1:0] core_in_o,
    input wire [`JDRC_DBG_W-1:0] dp_capture_i,
    input wire [`JDRC_DBG_W-1:0] ap_capture_i,
    output reg [`JDRC_DBG_W-1:0] dbg_data_o,
    output reg dp_update_o,
    output reg ap_update_o,
    output reg cancel_o
);

    // Controller states.
    localparam [3:0] ST_RESET = 4'h0;
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_SEL_DR = 4'h2;
    localparam [3:0] ST_CAP_DR = 4'h3;
    localparam [3:0] ST_SH_DR = 4'h4;
    localparam [3:0] ST_EX1_DR = 4'h5;
    localparam [3:0] ST_PAU_DR = 4'h6;
    localparam [3:0] ST_EX2_DR = 4'h7;
    localparam [3:0] ST_UPD_DR = 4'h8;
    localparam [3:0] ST_SEL_IR = 4'h9;
    localparam [3:0] ST_CAP_IR = 4'hA;
    localparam [3:0] ST_SH_IR = 4'hB;
    localparam [3:0] ST_EX1_IR = 4'hC;
    localparam [3:0] ST_PAU_IR = 4'hD;
    localparam [3:0] ST_EX2_IR = 4'hE;
    localparam [3:0] ST_UPD_IR = 4'hF;

    // Chain selection codes.
    localparam [2:0] SEL_BYP = 3'h0;
    localparam [2:0] SEL_ID = 3'h1;
    localparam [2:0] SEL_BSR = 3'h2;
    localparam [2:0] SEL_DP = 3'h3;
    localparam [2:0] SEL_AP = 3'h4;
    localparam [2:0] SEL_CAN = 3'h5;

    reg [3:0] meta_q;
    reg [3:0] sync_q;
    reg tck_prev_q;
    reg [3:0] state_q;
    reg [3:0] state_d;
    reg [`JDRC_IR_W-1:0] ir_q;
    reg [`JDRC_IR_W-1:0] ir_sh_q;
    reg [`JDRC_ID_W-1:0] id_sh_q;
    reg byp_q;
    reg [`JDRC_DBG_W-1:0] dbg_sh_q;
    wire tck_s;
    wire tms_s;
    wire tdi_s;
    wire trst_s;
    wire rst_all;
    wire rise;
    wire fall;
    wire [2:0] sel;
    wire bsr_so;
    wire dr_cap;
    wire dr_sh;
    wire dr_upd;

    // Decodes an instruction into the chain it connects; unknown codes fall to bypass.
    function [2:0] chain_of;
        input [`JDRC_IR_W-1:0] code;
        begin
            case (code)
                `JDRC_IR_EXTEST: chain_of = SEL_BSR;
                `JDRC_IR_INTEST: chain_of = SEL_BSR;
                `JDRC_IR_SAMPLE: chain_of = SEL_BSR;
                `JDRC_IR_IDCODE: chain_of = SEL_ID;
                `JDRC_IR_DP_CHAIN: chain_of = SEL_DP;
                `JDRC_IR_AP_CHAIN: chain_of = SEL_AP;
                `JDRC_IR_CANCEL: chain_of = SEL_CAN;
                default: chain_of = SEL_BYP;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Port pins are asynchronous to the system clock, so each passes two flip-flops.
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            meta_q <= 4'h0;
            sync_q <= 4'h0;
            tck_prev_q <= 1'b0;
        end else begin
            meta_q <= {trst_n_i, tdi_i, tms_i, tck_i};
            sync_q <= meta_q;
            tck_prev_q <= sync_q[0];
        end
    end

    assign tck_s = sync_q[0];
    assign tms_s = sync_q[1];
    assign tdi_s = sync_q[2];
    assign trst_s = sync_q[3];
    // Test reset needs no TCK; a low synchronised level forces the reset state.
    assign rst_all = !rst_n_i || !trst_s;
    // TCK edges seen by the system clock; TCK must be well below a quarter of its rate.
    assign rise = tck_s && !tck_prev_q;
    assign fall = !tck_s && tck_prev_q;

    assign sel = chain_of(ir_q);
    assign dr_cap = rise && (state_q == ST_CAP_DR);
    assign dr_sh = rise && (state_q == ST_SH_DR);
    assign dr_upd = fall && (state_q == ST_UPD_DR);

    ////////////////////////////////////////////////////////////////////////////////
    // Standard sixteen-state controller, stepped by TMS on each rising TCK.
    always @* begin
        case (state_q)
            ST_RESET: state_d = tms_s ? ST_RESET : ST_IDLE;
            ST_IDLE: state_d = tms_s ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: state_d = tms_s ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_d = tms_s ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: state_d = tms_s ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: state_d = tms_s ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: state_d = tms_s ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: state_d = tms_s ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: state_d = tms_s ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: state_d = tms_s ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: state_d = tms_s ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: state_d = tms_s ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: state_d = tms_s ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: state_d = tms_s ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: state_d = tms_s ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: state_d = tms_s ? ST_SEL_DR : ST_IDLE;
            default: state_d = ST_RESET;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Controller state and instruction register.
    always @(posedge clk_sys_i) begin
        if (rst_all) begin
            state_q <= ST_RESET;
            ir_q <= `JDRC_IR_IDCODE;
            ir_sh_q <= `JDRC_IR_CAPTURE;
        end else begin
            if (rise) begin
                state_q <= state_d;
                if (state_q == ST_CAP_IR) begin
                    ir_sh_q <= `JDRC_IR_CAPTURE;
                end else if (state_q == ST_SH_IR) begin
                    ir_sh_q <= {tdi_s, ir_sh_q[`JDRC_IR_W-1:1]};
                end
            end
            if (state_q == ST_RESET) begin
                ir_q <= `JDRC_IR_IDCODE;
            end else if (fall && (state_q == ST_UPD_IR)) begin
                ir_q <= ir_sh_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Identification, bypass and debug shifters; only the selected one moves.
    always @(posedge clk_sys_i) begin
        if (rst_all) begin
            id_sh_q <= {`JDRC_ID_W{1'b0}};
            byp_q <= `JDRC_BYPASS_CAPTURE;
            dbg_sh_q <= {`JDRC_DBG_W{1'b0}};
        end else begin
            if (dr_cap && sel == SEL_ID) begin
                id_sh_q <= `JDRC_IDCODE | 32'h0000_0001;
            end else if (dr_sh && sel == SEL_ID) begin
                id_sh_q <= {tdi_s, id_sh_q[`JDRC_ID_W-1:1]};
            end
            if (dr_cap && sel == SEL_BYP) begin
                byp_q <= `JDRC_BYPASS_CAPTURE;
            end else if (dr_sh && sel == SEL_BYP) begin
                byp_q <= tdi_s;
            end
            // One 35-bit shifter serves the three debug chains since only one is selected.
            if (dr_cap) begin
                case (sel)
                    SEL_DP: dbg_sh_q <= dp_capture_i;
                    SEL_AP: dbg_sh_q <= ap_capture_i;
                    SEL_CAN: dbg_sh_q <= {`JDRC_DBG_W{1'b0}};
                    default: dbg_sh_q <= dbg_sh_q;
                endcase
            end else if (dr_sh && (sel == SEL_DP || sel == SEL_AP || sel == SEL_CAN)) begin
                dbg_sh_q <= {tdi_s, dbg_sh_q[`JDRC_DBG_W-1:1]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Debug updates hand the shifted word out with a one-cycle strobe.
    always @(posedge clk_sys_i) begin
        if (rst_all) begin
            dbg_data_o <= {`JDRC_DBG_W{1'b0}};
            dp_update_o <= 1'b0;
            ap_update_o <= 1'b0;
            cancel_o <= 1'b0;
        end else begin
            if (dr_upd && (sel == SEL_DP || sel == SEL_AP || sel == SEL_CAN)) begin
                dbg_data_o <= dbg_sh_q;
            end
            dp_update_o <= dr_upd && (sel == SEL_DP);
            ap_update_o <= dr_upd && (sel == SEL_AP);
            cancel_o <= dr_upd && (sel == SEL_CAN);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // TDO follows the selected chain's bit 0 and changes only on falling TCK.
    always @(posedge clk_sys_i) begin
        if (rst_all) begin
            tdo_o <= 1'b0;
            tdo_oe_o <= 1'b0;
        end else if (fall) begin
            tdo_oe_o <= (state_q == ST_SH_DR) || (state_q == ST_SH_IR);
            if (state_q == ST_SH_IR) begin
                tdo_o <= ir_sh_q[0];
            end else begin
                case (sel)
                    SEL_ID: tdo_o <= id_sh_q[0];
                    SEL_BSR: tdo_o <= bsr_so;
                    SEL_DP: tdo_o <= dbg_sh_q[0];
                    SEL_AP: tdo_o <= dbg_sh_q[0];
                    SEL_CAN: tdo_o <= dbg_sh_q[0];
                    default: tdo_o <= byp_q;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Boundary chain; external and internal test use its held values.
    jdrc_bsr u_bsr (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(!rst_all),
        .capture_i(dr_cap && sel == SEL_BSR),
        .shift_i(dr_sh && sel == SEL_BSR),
        .update_i(dr_upd && sel == SEL_BSR),
        .tdi_i(tdi_s),
        .extest_i(ir_q == `JDRC_IR_EXTEST),
        .intest_i(ir_q == `JDRC_IR_INTEST),
        .pad_in_i(pad_in_i),
        .core_out_i(core_out_i),
        .core_oe_i(core_oe_i),
        .so_o(bsr_so),
        .pad_out_o(pad_out_o),
        .pad_oe_o(pad_oe_o),
        .core_in_o(core_in_o)
    );

endmodule

// ==== bench/jdrc_chains_asserts.sv ====
// Port-level property checker for the scan-chain block.
`timescale 1ns/100ps
`include "jdrc_map.vh"

module jdrc_chains_asserts (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire trst_n_i,
    input wire tck_i,
    input wire tdo_o,
    input wire tdo_oe_o,
    input wire [`JDRC_DBG_W-1:0] dbg_data_o,
    input wire dp_update_o,
    input wire ap_update_o,
    input wire cancel_o
);
    reg [3:0] trst_q;
    wire quiet;
    wire any_upd;
    ////////////////////////////////////////////////////////////////////////
    // Test reset passes a synchroniser, so checks rest until it has settled.
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            trst_q <= 4'h0;
        end else begin
            trst_q <= {trst_q[2:0], trst_n_i};
        end
    end
    assign quiet = rst_n_i && trst_n_i && (&trst_q);
    assign any_upd = dp_update_o || ap_update_o || cancel_o;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!quiet);
    ////////////////////////////////////////////////////////////////////////
    // Update strobes are single-cycle and come from falling TCK only.
    dp_pulse_once_a: assert property (dp_update_o |=> !dp_update_o)
        else $error("debug-port update pulse too long");
    ap_pulse_once_a: assert property (ap_update_o |=> !ap_update_o)
        else $error("access-port update pulse too long");
    cancel_pulse_once_a: assert property (cancel_o |=> !cancel_o)
        else $error("cancel pulse too long");
    update_exclusive_a: assert property ($onehot0({dp_update_o, ap_update_o, cancel_o}))
        else $error("two debug chains updated together");
    dbg_word_hold_a: assert property ($changed(dbg_data_o) |-> any_upd)
        else $error("debug word changed without an update");
    tdo_fall_edge_a: assert property ($changed(tdo_o) |-> !$past(tck_i, 3))
        else $error("tdo changed away from a falling test clock");
    tdo_en_fall_a: assert property ($changed(tdo_oe_o) |-> !$past(tck_i, 3))
        else $error("tdo enable changed away from a falling test clock");
    update_fall_a: assert property (any_upd |-> !$past(tck_i, 3))
        else $error("debug update not on a falling test clock");
    update_idle_a: assert property (any_upd |-> !tdo_oe_o [*3])
        else $error("tdo driven around a debug update");
endmodule

bind jdrc_chains jdrc_chains_asserts jdrc_chains_asserts_inst (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .trst_n_i(trst_n_i), .tck_i(tck_i), .tdo_o(tdo_o),
    .tdo_oe_o(tdo_oe_o), .dbg_data_o(dbg_data_o), .dp_update_o(dp_update_o),
    .ap_update_o(ap_update_o), .cancel_o(cancel_o));

// ==== bench/jdrc_probe.sv ====
// Behavioural scan probe that drives the test link and collects TDO.
`timescale 1ns/100ps

module jdrc_probe (
    input wire clk_sys_i,
    input wire tdo_i,
    output reg tck_o,
    output reg tms_o,
    output reg tdi_o
);
    reg junk;
    integer i;
    // TCK rests low between frames so no edge is seen outside a scan.
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // One TCK period of five clocks low and three high; TDO is taken before the rise.
    task step(input m, input d, output o);
        begin
            @(posedge clk_sys_i);
            #1;
            tms_o = m;
            tdi_o = d;
            repeat (4) @(posedge clk_sys_i);
            #1;
            o = tdo_i;
            tck_o = 1'b1;
            repeat (3) @(posedge clk_sys_i);
            #1;
            tck_o = 1'b0;
            tdi_o = ~d; // Spent data shows its inverse so stale bits never pass.
        end
    endtask
    // Five TMS highs reach Test-Logic-Reset, then one low parks in Idle.
    task tap_reset;
        begin
            for (i = 0; i < 5; i = i + 1) step(1'b1, 1'b0, junk);
            step(1'b0, 1'b0, junk);
        end
    endtask
    // Full scan from Idle: instruction or data path, LSB first, ends in Idle.
    task scan(input ir, input integer n, input [63:0] din, output [63:0] dout);
        begin
            dout = 64'h0;
            step(1'b0, 1'b0, junk);
            step(1'b1, 1'b0, junk);
            if (ir) step(1'b1, 1'b0, junk);
            step(1'b0, 1'b0, junk);
            step(1'b0, 1'b0, junk);
            for (i = 0; i < n; i = i + 1) step(i == n - 1, din[i], dout[i]);
            step(1'b1, 1'b0, junk);
            step(1'b0, 1'b0, junk);
        end
    endtask
endmodule

// ==== bench/tb.sv ====
// Self-checking bench for the scan-chain block with a behavioural probe.
`timescale 1ns/100ps
`include "jdrc_map.vh"

module tb;
    reg clk_sys_i, rst_n_i, trst_n_i;
    reg [7:0] pad_in_i, core_out_i, core_oe_i;
    reg [34:0] dp_capture_i, ap_capture_i;
    wire tck, tms, tdi, tdo_o, tdo_oe_o, dp_update_o, ap_update_o, cancel_o;
    wire [7:0] pad_out_o, pad_oe_o, core_in_o;
    wire [34:0] dbg_data_o;
    wire tdo_line;
    reg [31:0] seed;
    reg [63:0] r, dout, exp, hold;
    reg [3:0] code;
    integer fail_count, n_checks, cyc, c, p, k;
    integer n_upd [0:2];

    jdrc_chains jdrc_chains_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .tck_i(tck),
        .tms_i(tms), .tdi_i(tdi), .trst_n_i(trst_n_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
        .pad_in_i(pad_in_i), .core_out_i(core_out_i), .core_oe_i(core_oe_i),
        .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .core_in_o(core_in_o),
        .dp_capture_i(dp_capture_i), .ap_capture_i(ap_capture_i), .dbg_data_o(dbg_data_o),
        .dp_update_o(dp_update_o), .ap_update_o(ap_update_o), .cancel_o(cancel_o));
    // A released TDO shows the inverse of its last level, so sampling it undriven fails.
    assign tdo_line = tdo_oe_o ? tdo_o : ~tdo_o;
    jdrc_probe jdrc_probe_inst (.clk_sys_i(clk_sys_i), .tdo_i(tdo_line), .tck_o(tck),
        .tms_o(tms), .tdi_o(tdi));

    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    ////////////////////////////////////////////////////////////////////////
    // Strobes last one cycle, so they are counted every cycle; the ceiling cuts hangs.
    always @(posedge clk_sys_i) begin
        cyc = cyc + 1;
        if (dp_update_o === 1'b1) n_upd[0] = n_upd[0] + 1;
        if (ap_update_o === 1'b1) n_upd[1] = n_upd[1] + 1;
        if (cancel_o === 1'b1) n_upd[2] = n_upd[2] + 1;
        if (cyc == 60000) begin
            fail_count = fail_count + 1;
            close_out;
        end
    end
    task chk(input string what, input [63:0] e, input [63:0] g);
        begin
            n_checks = n_checks + 1;
            if (g !== e) begin
                fail_count = fail_count + 1;
                $display("wrong value %s: expected %h, seen %h", what, e, g);
            end
        end
    endtask
    // Maximal-length shift register step seeded at 42.
    function [31:0] lfsr_next(input [31:0] s);
        begin
            lfsr_next = {s[30:0], ^(s & 32'h8020_0003)};
        end
    endfunction
    task next_rnd;
        begin
            seed = lfsr_next(seed);
            r = {r[31:0], seed};
        end
    endtask
    task drive_pins;
        begin
            @(posedge clk_sys_i);
            #1;
            next_rnd;
            next_rnd;
            pad_in_i = r[7:0];
            core_out_i = r[15:8];
            core_oe_i = r[23:16];
            dp_capture_i = r[34:0];
            ap_capture_i = r[63:29];
            repeat (4) @(posedge clk_sys_i);
        end
    endtask
    task read_id;
        begin
            next_rnd;
            jdrc_probe_inst.scan(1'b0, 32, r, dout);
            chk("identification", {32'h0, `JDRC_IDCODE | 32'h1}, dout);
        end
    endtask
    task close_out;
        begin
            $display("checks %0d, mismatches %0d", n_checks, fail_count);
            if (fail_count == 0 && n_checks > 0) begin
                $display("All checks passed");
            end else begin
                $display("Checks failed");
            end
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence: identification after each reset, bypass codes, boundary, debug.
    initial begin
        rst_n_i = 1'b0;
        trst_n_i = 1'b1;
        {pad_in_i, core_out_i, core_oe_i, dp_capture_i, ap_capture_i} = 94'h0;
        {seed, r, fail_count, n_checks, cyc} = {32'h0000_002A, 64'h0, 96'h0};
        {n_upd[0], n_upd[1], n_upd[2]} = 96'h0;
        repeat (2) @(posedge clk_sys_i);
        #1;
        rst_n_i = 1'b1;
        repeat (6) @(posedge clk_sys_i);
        read_id;
        // Every unassigned code must behave as a one-flop delay path.
        for (c = 0; c < 16; c = c + 1) begin
            code = c;
            if (!(code inside {4'h0, 4'h1, 4'h2, 4'h8, 4'hA, 4'hB, 4'hE})) begin
                jdrc_probe_inst.scan(1'b1, 4, {60'h0, code}, dout);
                next_rnd;
                jdrc_probe_inst.scan(1'b0, 8, r, dout);
                chk("bypass path", {r[6:0], 1'b0}, dout);
            end
        end
        jdrc_probe_inst.tap_reset;
        read_id;
        jdrc_probe_inst.scan(1'b1, 4, {60'h0, `JDRC_IR_BYPASS}, dout);
        @(posedge clk_sys_i);
        #1;
        trst_n_i = 1'b0;
        repeat (5) @(posedge clk_sys_i);
        #1;
        trst_n_i = 1'b1;
        repeat (6) @(posedge clk_sys_i);
        read_id;
        // Sample the pads, shift the preload through, and keep the tail in the latches.
        drive_pins;
        jdrc_probe_inst.scan(1'b1, 4, {60'h0, `JDRC_IR_SAMPLE}, dout);
        next_rnd;
        next_rnd;
        exp = {16'h0, r[23:0], 24'h0};
        for (p = 0; p < 8; p = p + 1) begin
            exp[3*p+:3] = {core_oe_i[p], core_out_i[p], pad_in_i[p]};
            {hold[16+p], hold[8+p], hold[p]} = r[24+3*p+:3];
        end
        jdrc_probe_inst.scan(1'b0, 48, r, dout);
        chk("boundary scan", exp, dout);
        chk("pads follow core", {core_oe_i, core_out_i}, {pad_oe_o, pad_out_o});
        chk("core follows pads", pad_in_i, core_in_o);
        jdrc_probe_inst.scan(1'b1, 4, {60'h0, `JDRC_IR_EXTEST}, dout);
        chk("instruction capture", `JDRC_IR_CAPTURE, dout);
        repeat (3) @(posedge clk_sys_i);
        #1;
        chk("extest pads", {hold[23:16], hold[15:8]}, {pad_oe_o, pad_out_o});
        jdrc_probe_inst.scan(1'b1, 4, {60'h0, `JDRC_IR_INTEST}, dout);
        repeat (3) @(posedge clk_sys_i);
        #1;
        chk("intest core", hold[7:0], core_in_o);
        chk("intest pads", {core_oe_i, core_out_i}, {pad_oe_o, pad_out_o});
        // Each debug chain: capture word out, shifted word and one strobe back.
        for (k = 0; k < 3; k = k + 1) begin
            drive_pins;
            code = (k == 0) ? `JDRC_IR_DP_CHAIN : (k == 1) ? `JDRC_IR_AP_CHAIN : `JDRC_IR_CANCEL;
            exp = (k == 0) ? dp_capture_i : (k == 1) ? ap_capture_i : 64'h0;
            jdrc_probe_inst.scan(1'b1, 4, {60'h0, code}, dout);
            next_rnd;
            next_rnd;
            jdrc_probe_inst.scan(1'b0, 35, r, dout);
            chk("debug chain capture", exp, dout);
            chk("debug chain word", r[34:0], dbg_data_o);
            chk("update strobes", 1, n_upd[k]);
        end
        close_out;
    end
endmodule
